//--- dma_channel.sv
// The address map and the AXI4-Lite interface to the registers were left to the implementer.
`default_nettype none
module dma_channel
  import dma_pkg::*;
(
  input  wire logic              CLK_SYS,
  input  wire logic              RESET,
  input  wire logic [AXI_AW-1:0] AWADDR,
  input  wire logic              AWVALID,
  output logic                   AWREADY,
  input  wire logic [31:0]       WDATA,
  input  wire logic [3:0]        WSTRB,
  input  wire logic              WVALID,
  output logic                   WREADY,
  output logic [1:0]             BRESP,
  output logic                   BVALID,
  input  wire logic              BREADY,
  input  wire logic [AXI_AW-1:0] ARADDR,
  input  wire logic              ARVALID,
  output logic                   ARREADY,
  output logic [31:0]            RDATA,
  output logic [1:0]             RRESP,
  output logic                   RVALID,
  input  wire logic              RREADY,
  output sysbus_out_s            SBUS_OUT,
  input  wire sysbus_in_s        SBUS_IN,
  output logic                   BUS_REQ,
  input  wire logic              BUS_GRANT,
  input  wire logic              XFER_REQ_N,
  output logic                   XFER_ACK_N,
  input  wire logic              DONE_IN_N,
  output logic                   DONE_OUT_N,
  output logic                   DONE_OE_N
);
  // Byte-enable merge of a bus write into a register image
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  logic [23:0]       src_reg;
  logic [23:0]       dst_reg;
  logic [7:0]        fc_reg;
  logic [15:0]       cnt_reg;
  logic [15:0]       mode_reg;
  logic [3:0]        flags_reg;
  logic              aw_hold_reg;
  logic [AXI_AW-1:0] aw_addr_reg;
  logic              w_hold_reg;
  logic [31:0]       w_data_reg;
  logic [3:0]        w_strb_reg;
  dma_state_e        state_reg;
  logic              cyc_reg;
  logic              bi_reg;
  logic              nb_reg;
  logic [15:0]       hold_reg;
  logic              done_seen_reg;
  logic              edge_pend_reg;
  logic              req_prev_reg;
  sysbus_out_s       sb_reg;

  // AXI write side: address and data taken in either order, then committed
  logic aw_take;
  logic w_take;
  logic wr_do;
  logic rd_do;
  logic wr_hit;
  assign aw_take = AWVALID && AWREADY;
  assign w_take  = WVALID && WREADY;
  assign wr_do   = aw_hold_reg && w_hold_reg && !BVALID;
  assign rd_do   = ARVALID && ARREADY;

  // Register write decode
  logic wr_src;
  logic wr_dst;
  logic wr_fc;
  logic wr_cnt;
  logic wr_mode;
  logic wr_flags;
  assign wr_src   = wr_do && aw_addr_reg == OFS_SRC;
  assign wr_dst   = wr_do && aw_addr_reg == OFS_DST;
  assign wr_fc    = wr_do && aw_addr_reg == OFS_FC;
  assign wr_cnt   = wr_do && aw_addr_reg == OFS_CNT;
  assign wr_mode  = wr_do && aw_addr_reg == OFS_MODE;
  assign wr_flags = wr_do && aw_addr_reg == OFS_FLAGS;
  assign wr_hit   = wr_src | wr_dst | wr_fc | wr_cnt | wr_mode | wr_flags;

  logic [31:0] src_m;
  logic [31:0] dst_m;
  logic [31:0] fc_m;
  logic [31:0] cnt_m;
  logic [31:0] mode_m;
  assign src_m  = merge({8'h00, src_reg}, w_data_reg, w_strb_reg);
  assign dst_m  = merge({8'h00, dst_reg}, w_data_reg, w_strb_reg);
  assign fc_m   = merge({24'h000000, fc_reg}, w_data_reg, w_strb_reg);
  assign cnt_m  = merge({16'h0000, cnt_reg}, w_data_reg, w_strb_reg);
  assign mode_m = merge({16'h0000, mode_reg}, w_data_reg, w_strb_reg);

  // Read mux; reserved bits and unmapped offsets read zero
  logic [31:0] rd_word;
  logic        rd_ok;
  assign rd_ok = ARADDR == OFS_SRC || ARADDR == OFS_DST || ARADDR == OFS_FC
              || ARADDR == OFS_CNT || ARADDR == OFS_MODE || ARADDR == OFS_FLAGS;
  assign rd_word = (ARADDR == OFS_SRC)   ? {8'h00, src_reg} :
                   (ARADDR == OFS_DST)   ? {8'h00, dst_reg} :
                   (ARADDR == OFS_FC)    ? {24'h000000, fc_reg} :
                   (ARADDR == OFS_CNT)   ? {16'h0000, cnt_reg} :
                   (ARADDR == OFS_MODE)  ? {16'h0000, mode_reg} :
                   (ARADDR == OFS_FLAGS) ? {28'h0000000, flags_reg} :
                   32'h00000000;

  // Mode decode
  logic soft_rst;
  logic clr_all;
  logic start;
  logic ext_mode;
  logic ext_side;
  logic s_word;
  logic d_word;
  req_mode_e req_mode;
  assign soft_rst = mode_reg[M_RST];
  assign clr_all  = RESET | soft_rst;
  assign start    = mode_reg[M_START];
  assign req_mode = req_mode_e'(mode_reg[M_REQM +: 2]);
  assign ext_mode = mode_reg[M_REQM + 1];
  assign ext_side = mode_reg[M_SIDE];
  assign s_word   = mode_reg[M_SWIDTH +: 2] == SIZE_WORD;
  assign d_word   = mode_reg[M_DWIDTH +: 2] == SIZE_WORD;

  // Access planning for the current bus cycle
  logic        is_rd;
  logic [23:0] ptr;
  logic        two_n;
  logic        acc_word;
  logic        last_acc;
  logic        periph_side;
  logic        final_op;
  logic        final_cyc;
  logic [23:0] step;
  logic [15:0] cnt_step;
  logic [7:0]  lane;
  logic [7:0]  wbyte;
  assign is_rd       = state_reg == ST_READ;
  assign ptr         = is_rd ? src_reg : dst_reg;
  // A count of one limits the operand to one byte, so odd totals end exactly
  assign two_n       = (s_word | d_word) && cnt_reg != 16'h0001;
  assign acc_word    = (is_rd ? s_word : d_word) && !ptr[0] && nb_reg && !bi_reg;
  assign last_acc    = acc_word || bi_reg == nb_reg;
  assign periph_side = ext_mode && (is_rd ? !ext_side : ext_side);
  assign final_op    = cnt_reg == (nb_reg ? 16'h0002 : 16'h0001);
  assign final_cyc   = final_op && last_acc && (ext_mode ? periph_side : !is_rd);
  assign step        = acc_word ? 24'h000002 : 24'h000001;
  assign cnt_step    = acc_word ? 16'h0002 : 16'h0001;
  assign lane        = ptr[0] ? SBUS_IN.rdata[7:0] : SBUS_IN.rdata[15:8];
  assign wbyte       = bi_reg ? hold_reg[7:0] : hold_reg[15:8];

  // Request qualification; the edge latch only arms while started
  logic fell;
  logic trigger;
  assign fell    = req_prev_reg && !XFER_REQ_N;
  assign trigger = start && (!ext_mode || (req_mode == REQ_BURST ? !XFER_REQ_N
                                                                 : edge_pend_reg));

  // Bus cycle outcome and events
  logic acked;
  logic errd;
  logic done_hit;
  logic op_end;
  logic set_done;
  logic hw_stop;
  logic [3:0] set_flags;
  assign acked    = cyc_reg && SBUS_IN.ack && !SBUS_IN.err;
  assign errd     = cyc_reg && SBUS_IN.err;
  // Ignore the end line while we drive it ourselves
  assign done_hit = cyc_reg && !DONE_IN_N && DONE_OE_N
                 && (!ext_mode || periph_side);
  assign op_end   = acked && !is_rd && last_acc;
  assign set_done = op_end && (final_op || done_seen_reg || done_hit);
  assign hw_stop  = set_done | errd;
  assign set_flags[F_DONE] = set_done;
  assign set_flags[F_WF]   = errd && !is_rd;
  assign set_flags[F_RF]   = errd && is_rd;
  assign set_flags[F_UNSYNC] = done_hit && ext_mode && !last_acc;

  // AXI handshake registers; only the hard reset touches them
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      AWREADY     <= 1'b0;
      WREADY      <= 1'b0;
      BVALID      <= 1'b0;
      BRESP       <= RESP_OKAY;
      ARREADY     <= 1'b0;
      RVALID      <= 1'b0;
      RDATA       <= 32'h00000000;
      RRESP       <= RESP_OKAY;
    end else begin
      aw_hold_reg <= (aw_hold_reg | aw_take) & ~wr_do;
      w_hold_reg  <= (w_hold_reg | w_take) & ~wr_do;
      AWREADY     <= !((aw_hold_reg | aw_take) & ~wr_do);
      WREADY      <= !((w_hold_reg | w_take) & ~wr_do);
      BVALID      <= wr_do | (BVALID & ~BREADY);
      if (wr_do) begin
        BRESP <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      ARREADY <= !(rd_do | (RVALID & ~RREADY));
      RVALID  <= rd_do | (RVALID & ~RREADY);
      if (rd_do) begin
        RDATA <= rd_word;
        RRESP <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (aw_take) begin
      aw_addr_reg <= AWADDR;
    end
    if (w_take) begin
      w_data_reg <= WDATA;
      w_strb_reg <= WSTRB;
    end
  end

  // Mode word and flags; a software write of the start bit beats a hardware stop
  always_ff @(posedge CLK_SYS) begin
    if (clr_all) begin
      mode_reg  <= MODE_RST;
      flags_reg <= FLAGS_RST;
    end else begin
      if (wr_mode) begin
        mode_reg <= {1'b0, mode_m[14:0]};
      end else if (hw_stop) begin
        mode_reg[M_START] <= 1'b0;
      end
      // Set wins over a same-cycle clear
      flags_reg <= (flags_reg & ~(wr_flags && w_strb_reg[0] ? w_data_reg[3:0] : 4'h0))
                 | set_flags;
    end
  end

  // Pointers, count and space codes survive a software reset
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      src_reg <= PTR_RST;
      dst_reg <= PTR_RST;
      fc_reg  <= FC_RST;
      cnt_reg <= CNT_RST;
    end else begin
      if (wr_src) begin
        src_reg <= src_m[23:0];
      end else if (acked && is_rd && mode_reg[M_SINC]) begin
        src_reg <= src_reg + step;
      end
      if (wr_dst) begin
        dst_reg <= dst_m[23:0];
      end else if (acked && !is_rd && mode_reg[M_DINC]) begin
        dst_reg <= dst_reg + step;
      end
      if (wr_fc) begin
        fc_reg <= fc_m[7:0];
      end
      if (wr_cnt) begin
        cnt_reg <= cnt_m[15:0];
      end else if (acked && !is_rd) begin
        cnt_reg <= cnt_reg - cnt_step;
      end
    end
  end

  // Channel sequencer: idle, wait for grant, read phase, write phase
  always_ff @(posedge CLK_SYS) begin
    if (clr_all) begin
      state_reg     <= ST_IDLE;
      cyc_reg       <= 1'b0;
      bi_reg        <= 1'b0;
      nb_reg        <= 1'b0;
      hold_reg      <= 16'h0000;
      done_seen_reg <= 1'b0;
      edge_pend_reg <= 1'b0;
      req_prev_reg  <= 1'b1;
      sb_reg        <= '0;
      BUS_REQ       <= 1'b0;
      XFER_ACK_N    <= 1'b1;
      DONE_OUT_N    <= 1'b1;
      DONE_OE_N     <= 1'b1;
    end else begin
      req_prev_reg  <= XFER_REQ_N;
      edge_pend_reg <= start && ((edge_pend_reg && !(state_reg == ST_IDLE && trigger))
                     | (fell && req_mode == REQ_STEAL));
      unique case (state_reg)
        ST_IDLE: begin
          if (trigger) begin
            state_reg <= ST_WAIT;
            BUS_REQ   <= 1'b1;
          end
        end
        ST_WAIT: begin
          if (!start) begin
            state_reg <= ST_IDLE;
            BUS_REQ   <= 1'b0;
          end else if (BUS_GRANT) begin
            state_reg     <= ST_READ;
            nb_reg        <= two_n;
            bi_reg        <= 1'b0;
            done_seen_reg <= 1'b0;
          end
        end
        ST_READ, ST_WRITE: begin
          if (!cyc_reg) begin
            // One idle clock between cycles keeps strobes cleanly framed
            cyc_reg       <= 1'b1;
            sb_reg.strobe <= 1'b1;
            sb_reg.addr   <= ptr;
            sb_reg.read   <= is_rd;
            sb_reg.fc     <= is_rd ? fc_reg[FC_SRC +: 3] : fc_reg[FC_DST +: 3];
            sb_reg.upper  <= acc_word | !ptr[0];
            sb_reg.lower  <= acc_word | ptr[0];
            sb_reg.wdata  <= acc_word ? hold_reg : {wbyte, wbyte};
            XFER_ACK_N    <= !periph_side;
            DONE_OUT_N    <= !final_cyc;
            DONE_OE_N     <= !final_cyc;
          end else begin
            done_seen_reg <= done_seen_reg | done_hit;
            if (acked || errd) begin
              cyc_reg       <= 1'b0;
              sb_reg.strobe <= 1'b0;
              XFER_ACK_N    <= 1'b1;
              DONE_OUT_N    <= 1'b1;
              DONE_OE_N     <= 1'b1;
            end
            if (errd) begin
              state_reg <= ST_IDLE;
              BUS_REQ   <= 1'b0;
            end else if (acked && is_rd) begin
              if (acc_word) begin
                hold_reg <= SBUS_IN.rdata;
              end else if (bi_reg) begin
                hold_reg[7:0] <= lane;
              end else begin
                hold_reg[15:8] <= lane;
              end
              state_reg <= last_acc ? ST_WRITE : ST_READ;
              bi_reg    <= !last_acc;
            end else if (acked) begin
              bi_reg <= !last_acc;
              if (last_acc) begin
                // Stop bit is checked only at operand boundaries
                state_reg <= ST_IDLE;
                BUS_REQ   <= 1'b0;
              end
            end
          end
        end
      endcase
    end
  end

  assign SBUS_OUT = sb_reg;

endmodule
`default_nettype wire

//--- dma_channel_props.sv
`default_nettype none
module dma_channel_props
  import dma_pkg::*;
(
  input wire logic        CLK_SYS,
  input wire logic        RESET,
  input wire logic        AWVALID,
  input wire logic        AWREADY,
  input wire logic        WVALID,
  input wire logic        WREADY,
  input wire logic        BVALID,
  input wire logic        ARVALID,
  input wire logic        ARREADY,
  input wire logic        RVALID,
  input wire sysbus_out_s SBUS_OUT,
  input wire sysbus_in_s  SBUS_IN,
  input wire logic        BUS_REQ,
  input wire logic        XFER_ACK_N,
  input wire logic        DONE_OUT_N,
  input wire logic        DONE_OE_N
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);

  // Bus cycle steps: waiting for an answer, then closing on it
  sequence s_cyc_wait;
    SBUS_OUT.strobe && !SBUS_IN.ack && !SBUS_IN.err;
  endsequence
  sequence s_cyc_end;
    SBUS_OUT.strobe && (SBUS_IN.ack || SBUS_IN.err);
  endsequence

  a_cycle_close: assert property (
    s_cyc_end |=> !SBUS_OUT.strobe) else $error("strobe held after answer");
  a_cycle_hold: assert property (
    s_cyc_wait |=> SBUS_OUT.strobe && $stable(SBUS_OUT.addr) && $stable(SBUS_OUT.fc))
    else $error("cycle changed before answer");
  a_end_pair: assert property (
    DONE_OUT_N == DONE_OE_N) else $error("end line drive and level differ");
  a_end_in_write: assert property (
    !DONE_OE_N |-> SBUS_OUT.strobe && (!SBUS_OUT.read || !XFER_ACK_N))
    else $error("end driven outside final cycle");
  a_ack_in_cycle: assert property (
    !XFER_ACK_N |-> SBUS_OUT.strobe) else $error("acknowledge outside bus cycle");
  a_req_covers: assert property (
    SBUS_OUT.strobe |-> BUS_REQ) else $error("bus cycle without request");
  a_write_resp: assert property (
    AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID) else $error("late write response");
  a_read_resp: assert property (
    ARVALID && ARREADY |=> RVALID) else $error("late read data");
endmodule

bind dma_channel dma_channel_props chk (.CLK_SYS, .RESET, .AWVALID, .AWREADY, .WVALID, .WREADY,
  .BVALID, .ARVALID, .ARREADY, .RVALID, .SBUS_OUT, .SBUS_IN, .BUS_REQ, .XFER_ACK_N,
  .DONE_OUT_N, .DONE_OE_N);
`default_nettype wire

//--- dma_pkg.sv
`default_nettype none
package dma_pkg;
  // Register byte offsets on the AXI4-Lite slave
  localparam int         AXI_AW    = 8;
  localparam logic [7:0] OFS_SRC   = 8'h00;
  localparam logic [7:0] OFS_DST   = 8'h04;
  localparam logic [7:0] OFS_FC    = 8'h08;
  localparam logic [7:0] OFS_CNT   = 8'h0c;
  localparam logic [7:0] OFS_MODE  = 8'h10;
  localparam logic [7:0] OFS_FLAGS = 8'h14;

  // Channel mode word field positions
  localparam int M_START  = 0;
  localparam int M_RST    = 1;
  localparam int M_BT     = 2;
  localparam int M_DWIDTH = 4;
  localparam int M_SWIDTH = 6;
  localparam int M_DINC   = 8;
  localparam int M_SINC   = 9;
  localparam int M_REQM   = 10;
  localparam int M_EIRQ   = 12;
  localparam int M_CIRQ   = 13;
  localparam int M_SIDE   = 14;

  // Event flag positions
  localparam int F_DONE = 0;
  localparam int F_WF   = 1;
  localparam int F_RF   = 2;
  localparam int F_UNSYNC = 3;

  // Space code fields inside the function code select register
  localparam int FC_DST = 0;
  localparam int FC_SRC = 4;

  // Reset values
  localparam logic [15:0] MODE_RST  = 16'h0000;
  localparam logic [3:0]  FLAGS_RST = 4'h0;
  localparam logic [7:0]  FC_RST    = 8'h00;
  localparam logic [23:0] PTR_RST   = 24'h000000;
  localparam logic [15:0] CNT_RST   = 16'h0000;

  localparam logic [1:0]  SIZE_WORD   = 2'b10;
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    REQ_LIMITED = 2'b00,
    REQ_MAX     = 2'b01,
    REQ_BURST   = 2'b10,
    REQ_STEAL   = 2'b11
  } req_mode_e;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WAIT  = 2'b01,
    ST_READ  = 2'b10,
    ST_WRITE = 2'b11
  } dma_state_e;

  // System bus cycle driven by the channel (all active high)
  typedef struct packed {
    logic [23:0] addr;
    logic [2:0]  fc;
    logic        read;
    logic        upper;
    logic        lower;
    logic        strobe;
    logic [15:0] wdata;
  } sysbus_out_s;

  // System bus answer (all active high)
  typedef struct packed {
    logic [15:0] rdata;
    logic        ack;
    logic        err;
  } sysbus_in_s;
endpackage
`default_nettype wire

//--- dma_sys_model.sv
`default_nettype none
module dma_sys_model
  import dma_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire sysbus_out_s bo,
  output sysbus_in_s       bi,
  input  wire logic        req,
  output logic             grant,
  input  wire logic [2:0]  lat,
  input  wire logic [23:0] err_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [0:255];
  logic [2:0]  wait_cnt;
  wire  logic [7:0] idx;
  wire  logic       hit_err;

  assign idx     = bo.addr[8:1];
  assign hit_err = (bo.addr == err_addr);

  // Grant one clock after request; data lines toggle when idle so stale data never looks valid
  always @(posedge clk) begin
    grant    <= req && !rst;
    bi.ack   <= 1'b0;
    bi.err   <= 1'b0;
    bi.rdata <= ~bi.rdata;
    if (rst) begin
      wait_cnt <= 3'h0;
      bi.rdata <= 16'h0000;
    end else if (bo.strobe && !bi.ack && !bi.err) begin
      if (wait_cnt != lat) begin
        wait_cnt <= wait_cnt + 3'h1;
      end else begin
        wait_cnt <= 3'h0;
        bi.err   <= hit_err;
        bi.ack   <= !hit_err;
        if (bo.read) begin
          bi.rdata <= mem[idx];
        end
        if (!bo.read && bo.upper) begin
          mem[idx][15:8] <= bo.wdata[15:8]; // Even byte rides the upper lane
        end
        if (!bo.read && bo.lower) begin
          mem[idx][7:0] <= bo.wdata[7:0];
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- testbench.sv
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end end
module testbench
  import dma_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [1:0] B = 2'b01;
  localparam logic [1:0] W = SIZE_WORD;
  logic              CLK_SYS = 0, RESET = 1, BREADY = 1, RREADY = 1;
  logic              AWVALID = 0, WVALID = 0, ARVALID = 0, XFER_REQ_N = 1;
  logic [AXI_AW-1:0] AWADDR = '0, ARADDR = '0;
  logic [31:0]       WDATA = '0, RDATA;
  logic [3:0]        WSTRB = 4'hf;
  logic              AWREADY, WREADY, BVALID, ARREADY, RVALID, BUS_REQ, BUS_GRANT;
  logic              XFER_ACK_N, DONE_OUT_N, DONE_OE_N;
  logic [1:0]        BRESP, RRESP, bres, rres;
  sysbus_out_s       SBUS_OUT;
  sysbus_in_s        SBUS_IN;
  logic              req_n = 1, tog = 0, end_n = 1;
  logic [2:0]        lat_v = 0, rfc, wfc;
  logic [23:0]       err_a = 24'h0a0a0a, raddr, waddr;
  logic              oe_q = 1;
  int                cyc = 0, rack = 0, wack = 0, ends = 0, error_cnt = 0, compares = 0;
  wire logic         DONE_IN_N;

  assign DONE_IN_N = end_n & (DONE_OE_N | DONE_OUT_N); // Wired end line
  initial forever #50 CLK_SYS = ~CLK_SYS;

  dma_channel uut (.*);
  dma_sys_model mdl (.clk(CLK_SYS), .rst(RESET), .bo(SBUS_OUT), .bi(SBUS_IN), .req(BUS_REQ),
    .grant(BUS_GRANT), .lat(lat_v), .err_addr(err_a));

  // Peripheral request driver and bus cycle monitor
  always @(posedge CLK_SYS) begin
    cyc <= cyc + 1;
    XFER_REQ_N <= tog ? cyc[1] : req_n;
    oe_q <= DONE_OE_N;
    if (oe_q && !DONE_OE_N) ends <= ends + 1;
    if (SBUS_OUT.strobe && SBUS_OUT.read) begin
      rfc <= SBUS_OUT.fc;
      raddr <= SBUS_OUT.addr;
      rack <= rack + int'(!XFER_ACK_N);
    end
    if (SBUS_OUT.strobe && !SBUS_OUT.read) begin
      wfc <= SBUS_OUT.fc;
      waddr <= SBUS_OUT.addr;
      wack <= wack + int'(!XFER_ACK_N);
    end
  end

  task automatic finish_test;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic hang;
    error_cnt++;
    $display("BAD wait exp answer got timeout");
    finish_test();
  endtask
  // AXI4-Lite master: both write channels offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge CLK_SYS);
      if (AWREADY && AWVALID) AWVALID <= 1'b0;
      if (WREADY && WVALID) WVALID <= 1'b0;
      if (BVALID) begin
        bres = BRESP;
        break;
      end
    end
    if (n == 40) hang();
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    ARADDR <= a;
    ARVALID <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge CLK_SYS);
      if (ARREADY) ARVALID <= 1'b0;
      if (RVALID) begin
        d = RDATA;
        rres = RRESP;
        break;
      end
    end
    if (n == 40) hang();
  endtask
  task automatic ck(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] d;
    rd(a, d);
    `CHK(nm, e, d)
  endtask
  function automatic logic [31:0] mw(input logic [1:0] rq, ss, ds, inc, input logic side);
    return 32'h1 | 32'(rq) << M_REQM | 32'(ss) << M_SWIDTH | 32'(ds) << M_DWIDTH
      | 32'(inc) << M_DINC | 32'(side) << M_SIDE;
  endfunction
  task automatic setup(input logic [23:0] s, dd, input logic [15:0] c);
    wr(OFS_SRC, 32'(s));
    wr(OFS_DST, 32'(dd));
    wr(OFS_CNT, 32'(c));
    wr(OFS_FC, 32'h52);
  endtask
  task automatic go_wait;
    logic [31:0] d;
    int n;
    for (n = 0; n < 300; n++) begin
      rd(OFS_MODE, d);
      if (d[M_START] === 1'b0) break;
    end
    if (n == 300) hang();
  endtask
  task automatic run(input logic [23:0] s, dd, input logic [15:0] c, input logic [31:0] m);
    setup(s, dd, c);
    wr(OFS_MODE, m);
    if (m[M_REQM+1] === 1'b0) begin
      `CHK("req early", 1'b0, BUS_REQ)
      #1 `CHK("req", 1'b1, BUS_REQ)
    end
    go_wait();
  endtask

  task automatic t_regs;
    logic [31:0] d;
    ck(OFS_FLAGS, 32'h0, "flags");
    ck(OFS_MODE, 32'h0, "mode");
    rd(8'h18, d);
    `CHK("unmapped rd", RESP_SLVERR, rres)
    wr(8'h18, 32'h1);
    `CHK("unmapped wr", RESP_SLVERR, bres)
    wr(OFS_SRC, 32'hffffffff);
    ck(OFS_SRC, 32'h00ffffff, "src top");
  endtask
  task automatic t_word;
    int e0 = ends;
    mdl.mem[8'h08] = 16'h1234;
    mdl.mem[8'h09] = 16'h5678;
    run(24'h10, 24'h80, 16'h4, mw(2'b01, W, W, 2'b11, 0));
    `CHK("word0", 16'h1234, mdl.mem[8'h40])
    `CHK("word1", 16'h5678, mdl.mem[8'h41])
    ck(OFS_SRC, 32'h14, "src");
    ck(OFS_DST, 32'h84, "dst");
    ck(OFS_CNT, 32'h0, "cnt");
    ck(OFS_FLAGS, 32'h1, "flags");
    `CHK("rd fc", 3'h5, rfc)
    `CHK("wr fc", 3'h2, wfc)
    `CHK("rd addr", 24'h12, raddr)
    `CHK("wr addr", 24'h82, waddr)
    `CHK("end drives", 1, ends - e0)
    wr(OFS_FLAGS, 32'h1);
  endtask
  task automatic t_wrap;
    mdl.mem[8'hff] = 16'h00a1;
    mdl.mem[8'h00] = 16'hb200;
    run(24'hffffff, 24'h100, 16'h2, mw(2'b00, B, B, 2'b11, 0));
    `CHK("bytes", 16'ha1b2, mdl.mem[8'h80])
    ck(OFS_SRC, 32'h1, "src wrap");
    mdl.mem[8'h10] = 16'h1111;
    mdl.mem[8'h11] = 16'h2233;
    mdl.mem[8'h51] = 16'hffff;
    run(24'h20, 24'ha0, 16'h3, mw(2'b01, W, W, 2'b11, 0));
    `CHK("odd tail", 16'h22ff, mdl.mem[8'h51])
    ck(OFS_CNT, 32'h0, "cnt odd");
    wr(OFS_FLAGS, 32'h1);
  endtask
  task automatic t_err;
    err_a <= 24'h30;
    run(24'h30, 24'hc0, 16'h2, mw(2'b01, W, W, 2'b00, 0));
    ck(OFS_FLAGS, 32'h4, "read fault");
    err_a <= 24'hc0;
    run(24'h32, 24'hc0, 16'h2, mw(2'b01, W, W, 2'b11, 0));
    ck(OFS_FLAGS, 32'h6, "write fault");
    err_a <= 24'h0a0a0a;
    wr(OFS_FLAGS, 32'h0);
    ck(OFS_FLAGS, 32'h6, "w0 keeps");
    wr(OFS_FLAGS, 32'h6);
    ck(OFS_FLAGS, 32'h0, "w1 clears");
  endtask
  task automatic t_ext;
    int r0 = rack, w0 = wack;
    mdl.mem[8'h60] = 16'habcd;
    setup(24'hc0, 24'he0, 16'h4);
    req_n <= 1'b0;
    wr(OFS_MODE, mw(2'b10, B, W, 2'b11, 0) & ~32'h1);
    repeat (10) @(posedge CLK_SYS);
    ck(OFS_CNT, 32'h4, "idle cnt");
    end_n <= 1'b0;
    wr(OFS_MODE, mw(2'b10, B, W, 2'b11, 0));
    go_wait();
    end_n <= 1'b1;
    req_n <= 1'b1;
    `CHK("packed", 16'habcd, mdl.mem[8'h70])
    ck(OFS_CNT, 32'h2, "cnt end");
    ck(OFS_FLAGS, 32'h9, "flags end");
    `CHK("rd ack", 1'b1, rack > r0)
    `CHK("wr ack", 1'b0, wack > w0)
    wr(OFS_MODE, 32'h2);
    ck(OFS_FLAGS, 32'h0, "soft flags");
    ck(OFS_MODE, 32'h0, "soft mode");
  endtask
  task automatic t_steal;
    int r0 = rack, w0 = wack, e0 = ends;
    mdl.mem[8'h68] = 16'h5aa5;
    tog <= 1'b1;
    run(24'hd0, 24'hf0, 16'h2, mw(2'b11, B, B, 2'b11, 1));
    tog <= 1'b0;
    `CHK("steal data", 16'h5aa5, mdl.mem[8'h78])
    `CHK("rd ack", 1'b0, rack > r0)
    `CHK("wr ack", 1'b1, wack > w0)
    `CHK("end drives", 1, ends - e0)
    ck(OFS_FLAGS, 32'h1, "flags");
    wr(OFS_FLAGS, 32'h1);
  endtask
  task automatic t_stop;
    int n;
    mdl.mem[8'h23] = 16'h7e57;
    lat_v <= 3'h5;
    setup(24'h40, 24'h120, 16'h8);
    wr(OFS_MODE, mw(2'b01, W, W, 2'b11, 0));
    wr(OFS_MODE, mw(2'b01, W, W, 2'b11, 0) & ~32'h1);
    for (n = 0; n < 100 && BUS_REQ !== 1'b0; n++) @(posedge CLK_SYS);
    if (n == 100) hang();
    ck(OFS_CNT, 32'h6, "held cnt");
    ck(OFS_SRC, 32'h42, "held src");
    ck(OFS_FLAGS, 32'h0, "held flags");
    wr(OFS_MODE, mw(2'b01, W, W, 2'b11, 0));
    go_wait();
    lat_v <= 3'h0;
    `CHK("resumed", 16'h7e57, mdl.mem[8'h93])
    ck(OFS_FLAGS, 32'h1, "flags");
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge CLK_SYS);
    RESET <= 1'b0;
    @(posedge CLK_SYS);
    t_regs();
    t_word();
    t_wrap();
    t_err();
    t_ext();
    t_steal();
    t_stop();
    finish_test();
  end
endmodule
`default_nettype wire
